// ===== hdl/mff_fcs_unit.sv
// fcs generator and checker with header parsing for mac frames
//
// What this block does
// (R1) classify frames by security bit and version
// (R2) octet after frame control is sequence number
// (R3) auto-ack copies received sequence number
// (R4) destination address before source, pan first
// (R5) pan compression drops source pan id
// (R6) no-address frames only ack unless configured
// (R7) auxiliary security header only when b3 set
// (R8) crc over octets after length, appended last
// (R9) receive crc result in status bit
// (R10) on-fly tx crc, disabled by control bit
// (R11) polynomial x16 + x12 + x5 + 1
// (R12) b0 highest order, remainder is check field
// (R13) b0 first on air, r0 first
// (R14) crc over n-2 octets, replaces last two
// (R15) crc valid updated at frame done only
// (R16) auto-ack drops bad crc, no done irq
// (R17) zero init, no inversion, zero remainder passes
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module mff_fcs_unit
	import mff_pkg::*;
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	// register port
	input  wire mff_pkg::mff_bus_req_t bus_i,
	output logic [7:0]            rdata_o,
	output logic                  irq_o,
	// transmit: start pulse, frame length, serial bit out
	input  wire logic             tx_start_i,
	input  wire logic [6:0]       tx_len_i,
	input  wire logic             tx_ready_i,
	output logic                  tx_bit_o,
	output logic                  tx_valid_o,
	output logic                  tx_busy_o,
	// receive: serial bits, frame start and end
	input  wire logic             rx_bit_i,
	input  wire logic             rx_valid_i,
	input  wire logic             rx_sof_i,
	input  wire logic             rx_eof_i,
	// auto-ack request and parsed header view
	output logic                  ack_req_o,
	output logic [7:0]            ack_seq_o,
	output logic                  sec_hdr_o,
	output logic [4:0]            hdr_len_o
);
	import mff_pkg::*;

	// ------------------------------------------------------------
	// crc step: lsb of octet first, msb-first shift register
	// ------------------------------------------------------------
	function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_bit = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000); // R11 R12
	endfunction

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] ctrl_one;
	logic [7:0] cfg;
	logic [7:0] irq_stat;
	logic [7:0] irq_mask;
	logic       crc_valid;
	logic [7:0] seq_num;
	mff_class_t fclass;
	logic [7:0] fbuf [0:127];
	logic [2:0] irq_evt;
	logic [7:0] phy_status;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_one <= CTRL_ONE_RST;
			cfg      <= CFG_RST;
			irq_mask <= 8'h00;
		end else if (bus_i.wr) begin
			if (bus_i.addr == ADDR_CTRL_ONE)
				ctrl_one <= bus_i.wdata;
			if (bus_i.addr == ADDR_CFG)
				cfg <= bus_i.wdata;
			if (bus_i.addr == ADDR_IRQ_MASK)
				irq_mask <= bus_i.wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (bus_i.wr && bus_i.addr[5])
			fbuf[{1'b0, bus_i.addr[4:0]} + 7'h00] <= bus_i.wdata;
	end

	// set wins over write-one-to-clear
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			irq_stat <= 8'h00;
		else begin
			irq_stat <= (irq_stat & ~((bus_i.wr && bus_i.addr == ADDR_IRQ_STATUS) ?
				bus_i.wdata : 8'h00)) | {5'h00, irq_evt};
		end
	end
	assign irq_o = |(irq_stat & irq_mask);

	// status word: only the crc result bit is backed, the rest read zero
	always_comb begin
		phy_status                = 8'h00;
		phy_status[BIT_CRC_VALID] = crc_valid; // R9
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			rdata_o <= 8'h00;
		else if (bus_i.rd) begin
			case (bus_i.addr)
				ADDR_CTRL_ONE:   rdata_o <= ctrl_one;
				ADDR_PHY_STATUS: rdata_o <= phy_status; // R9
				ADDR_IRQ_STATUS: rdata_o <= irq_stat;
				ADDR_IRQ_MASK:   rdata_o <= irq_mask;
				ADDR_CFG:        rdata_o <= cfg;
				ADDR_SEQ:        rdata_o <= seq_num;
				ADDR_CLASS:      rdata_o <= {6'h00, fclass};
				default:         rdata_o <= bus_i.addr[5] ? fbuf[{2'b00, bus_i.addr[4:0]}] : 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// transmit
	// ------------------------------------------------------------
	logic [6:0]  tx_len;
	logic [6:0]  tx_idx;
	logic [2:0]  tx_bitn;
	logic [15:0] tx_crc;
	logic        tx_auto;
	logic        tx_in_fcs;
	logic [7:0]  tx_oct;
	logic        tx_step;

	assign tx_step   = tx_busy_o && tx_ready_i;
	assign tx_in_fcs = tx_auto && (tx_idx >= tx_len - 7'h02); // R14
	assign tx_oct    = fbuf[tx_idx];
	assign tx_valid_o = tx_busy_o;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_busy_o <= 1'b0;
			tx_idx    <= 7'h00;
			tx_bitn   <= 3'h0;
			tx_crc    <= CRC_INIT;
			tx_len    <= 7'h00;
			tx_auto   <= 1'b0;
			tx_bit_o  <= 1'b0;
		end else if (tx_start_i && !tx_busy_o && tx_len_i >= LEN_MIN) begin
			tx_busy_o <= 1'b1;
			tx_len    <= tx_len_i;
			tx_idx    <= 7'h00;
			tx_bitn   <= 3'h0;
			tx_crc    <= CRC_INIT; // R17
			tx_auto   <= ctrl_one[BIT_AUTO_CRC]; // R10
		end else if (tx_step) begin
			if (tx_in_fcs) begin
				// r0 is the msb of the remainder and leaves first
				tx_bit_o <= tx_crc[15]; // R13 R8
				tx_crc   <= {tx_crc[14:0], 1'b0};
			end else begin
				tx_bit_o <= tx_oct[tx_bitn]; // R13
				tx_crc   <= crc_bit(tx_crc, tx_oct[tx_bitn]); // R10
			end
			tx_bitn <= tx_bitn + 3'h1;
			if (tx_bitn == 3'h7) begin
				tx_idx <= tx_idx + 7'h01;
				if (tx_idx + 7'h01 == tx_len)
					tx_busy_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// receive: crc and header parse
	// ------------------------------------------------------------
	logic [15:0] rx_crc;
	logic [6:0]  rx_cnt;
	logic [2:0]  rx_bitn;
	logic [7:0]  rx_sh;
	logic [15:0] fcf;
	logic        oct_done;
	logic [7:0]  oct_val;
	logic [15:0] rx_crc_end;
	logic        crc_ok;
	logic        addr_ok;
	logic        ver_ok;
	logic        aack;
	logic [4:0]  dst_len;
	logic [4:0]  src_len;

	assign oct_done = rx_valid_i && rx_bitn == 3'h7;
	assign oct_val  = {rx_bit_i, rx_sh[7:1]};
	assign rx_crc_end = rx_valid_i ? crc_bit(rx_crc, rx_bit_i) : rx_crc;
	assign crc_ok   = (rx_crc_end == 16'h0000) && rx_cnt >= 7'h02; // R17
	assign aack     = cfg[CFG_AACK];

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_crc  <= CRC_INIT;
			rx_cnt  <= 7'h00;
			rx_bitn <= 3'h0;
			rx_sh   <= 8'h00;
		end else if (rx_sof_i) begin
			rx_crc  <= CRC_INIT; // R17
			rx_cnt  <= 7'h00;
			rx_bitn <= 3'h0;
		end else if (rx_valid_i) begin
			rx_crc  <= crc_bit(rx_crc, rx_bit_i); // R8
			rx_sh   <= oct_val;
			rx_bitn <= rx_bitn + 3'h1;
			if (oct_done && rx_cnt != LEN_MAX)
				rx_cnt <= rx_cnt + 7'h01;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fcf     <= 16'h0000;
			seq_num <= 8'h00;
		end else if (oct_done && !rx_sof_i) begin
			if (rx_cnt == 7'h00)
				fcf[7:0] <= oct_val;
			if (rx_cnt == 7'h01)
				fcf[15:8] <= oct_val;
			if (rx_cnt == 7'h02)
				seq_num <= oct_val; // R2
		end
	end

	// address field lengths: pan id then address, destination first
	always_comb begin
		dst_len = 5'h00;
		src_len = 5'h00;
		case (fcf[FCF_DST_LO +: 2])
			2'h2:    dst_len = 5'h04; // R4
			2'h3:    dst_len = 5'h0A; // R4
			default: dst_len = 5'h00;
		endcase
		case (fcf[FCF_SRC_LO +: 2])
			2'h2:    src_len = 5'h04;
			2'h3:    src_len = 5'h0A;
			default: src_len = 5'h00;
		endcase
		if (dst_len != 5'h00 && src_len != 5'h00 && fcf[FCF_PANCOMP])
			src_len = src_len - 5'h02; // R5
	end
	// header view is registered so it never glitches while fcf is loading
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hdr_len_o <= 5'h00;
			sec_hdr_o <= 1'b0;
		end else begin
			hdr_len_o <= HDR_FIXED + dst_len + src_len; // R4
			sec_hdr_o <= fcf[FCF_SEC]; // R7
		end
	end

	assign addr_ok = (dst_len != 5'h00) || (src_len != 5'h00) ||
		(fcf[2:0] == FT_ACK) || cfg[CFG_NO_ADDR]; // R6
	assign ver_ok  = !fcf[FCF_VER_LO + 1] || cfg[CFG_RES_VER];

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			fclass <= MFF_PLAIN_LEGACY;
		else begin
			case ({fcf[FCF_SEC], fcf[FCF_VER_LO]}) // R1
				2'b00:   fclass <= MFF_PLAIN_LEGACY;
				2'b01:   fclass <= MFF_PLAIN_NEW;
				2'b10:   fclass <= MFF_SEC_LEGACY;
				default: fclass <= MFF_SEC_NEW;
			endcase
		end
	end

	// ------------------------------------------------------------
	// frame end: crc status, done interrupt, auto-ack
	// ------------------------------------------------------------
	logic frame_done;
	assign frame_done = rx_eof_i && (!aack || (crc_ok && addr_ok && ver_ok)); // R16

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			crc_valid <= 1'b0;
			ack_req_o <= 1'b0;
			ack_seq_o <= 8'h00;
		end else begin
			ack_req_o <= 1'b0;
			if (frame_done)
				crc_valid <= crc_ok; // R15 R9
			if (rx_eof_i && aack && crc_ok && addr_ok && ver_ok && fcf[FCF_ACK_REQ]) begin
				ack_req_o <= 1'b1;
				ack_seq_o <= seq_num; // R3
			end
		end
	end

	always_comb begin
		irq_evt = 3'h0;
		irq_evt[IRQ_DONE]    = frame_done;
		irq_evt[IRQ_CRC_BAD] = rx_eof_i && !crc_ok;
		irq_evt[IRQ_FILT]    = rx_eof_i && !(addr_ok && ver_ok);
	end

endmodule

// ===== hdl/mff_pkg.sv
// package for the mac frame fcs unit: offsets, fields, reset values, types
package mff_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_CTRL_ONE   = 6'h04;
	localparam logic [5:0] ADDR_PHY_STATUS = 6'h06;
	localparam logic [5:0] ADDR_IRQ_STATUS = 6'h0F;
	localparam logic [5:0] ADDR_IRQ_MASK   = 6'h0E;
	localparam logic [5:0] ADDR_CFG        = 6'h17;
	localparam logic [5:0] ADDR_SEQ        = 6'h18;
	localparam logic [5:0] ADDR_CLASS      = 6'h19;
	localparam logic [5:0] ADDR_FB_BASE    = 6'h20;

	localparam int BIT_AUTO_CRC  = 5;
	localparam int BIT_CRC_VALID = 7;
	localparam logic [7:0] CTRL_ONE_RST = 8'h22;
	localparam logic [7:0] CFG_RST      = 8'h00;

	// cfg bits
	localparam int CFG_AACK      = 0;
	localparam int CFG_NO_ADDR   = 1;
	localparam int CFG_RES_VER   = 2;

	// irq bits
	localparam int IRQ_DONE      = 0;
	localparam int IRQ_CRC_BAD   = 1;
	localparam int IRQ_FILT      = 2;

	// ------------------------------------------------------------
	// frame fields
	// ------------------------------------------------------------
	localparam int FCF_SEC      = 3;
	localparam int FCF_PANCOMP  = 6;
	localparam int FCF_ACK_REQ  = 5;
	localparam logic [4:0] HDR_FIXED = 5'h03;
	localparam int FCF_DST_LO   = 10;
	localparam int FCF_VER_LO   = 12;
	localparam int FCF_SRC_LO   = 14;
	localparam logic [2:0] FT_ACK = 3'h2;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [15:0] CRC_INIT  = 16'h0000;
	localparam logic [6:0]  LEN_MIN   = 7'h03;
	localparam logic [6:0]  LEN_MAX   = 7'h7F;
	localparam logic [2:0]  ACK_LEN   = 3'h5;

	typedef enum logic [1:0] {
		MFF_PLAIN_LEGACY,
		MFF_PLAIN_NEW,
		MFF_SEC_LEGACY,
		MFF_SEC_NEW
	} mff_class_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} mff_bus_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} mff_octet_t;

endpackage

// ===== sim/mff_fcs_monitor.sv
// port checker for the mac frame fcs unit
`timescale 1ns/1ps
module mff_fcs_monitor
	import mff_pkg::*;
(
	// watched ports
	input wire logic                  clk_i,
	input wire logic                  rstn_i,
	input wire mff_pkg::mff_bus_req_t bus_i,
	input wire logic [7:0]            rdata_o,
	input wire logic                  tx_start_i,
	input wire logic [6:0]            tx_len_i,
	input wire logic                  tx_ready_i,
	input wire logic                  tx_bit_o,
	input wire logic                  tx_valid_o,
	input wire logic                  tx_busy_o,
	input wire logic                  rx_eof_i,
	input wire logic                  ack_req_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	a_rdata_holds: assert property (!$past(bus_i.rd) |-> $stable(rdata_o))
		else $error("read data moved without a read");
	a_status_clean: assert property (bus_i.rd && bus_i.addr == 6'h06 |=>
		rdata_o[6:0] == 7'h00) else $error("status spare bits set");
	a_valid_busy: assert property (tx_valid_o == tx_busy_o &&
		(!$rose(tx_busy_o) || $past(tx_start_i))) else $error("tx busy without start");
	a_start_taken: assert property (tx_start_i && !tx_busy_o && tx_len_i >= 7'h03
		|=> tx_busy_o [*8]) else $error("frame start not taken");
	a_short_refused: assert property (tx_start_i && !tx_busy_o && tx_len_i < 7'h03
		|=> !tx_busy_o) else $error("short frame started");
	a_bit_held: assert property (tx_busy_o && !tx_ready_i |=> $stable(tx_bit_o))
		else $error("tx bit moved without ready");
	a_ack_single: assert property (ack_req_o |=> !ack_req_o)
		else $error("ack request longer than one cycle");
	a_ack_cause: assert property (ack_req_o |-> $past(rx_eof_i))
		else $error("ack request without frame end");
endmodule
bind mff_fcs_unit mff_fcs_monitor mon (.clk_i, .rstn_i, .bus_i, .rdata_o, .tx_start_i,
	.tx_len_i, .tx_ready_i, .tx_bit_o, .tx_valid_o, .tx_busy_o, .rx_eof_i, .ack_req_o);

// ===== sim/mff_radio_model.sv
// radio side model: bit sink for the modulator, bit source for the demodulator
`timescale 1ns/1ps
module mff_radio_model (
	// modulator side
	input  wire logic clk_i,
	input  wire logic tx_bit_i,
	input  wire logic tx_valid_i,
	output logic      tx_ready_o,
	// demodulator side
	output logic      rx_bit_o,
	output logic      rx_valid_o,
	output logic      rx_sof_o,
	output logic      rx_eof_o
);
	logic slow;
	logic took;
	logic cap [$];
	initial begin
		{tx_ready_o, rx_bit_o, rx_valid_o, rx_sof_o, rx_eof_o, slow, took} = '0;
	end
	always @(posedge clk_i) begin
		if (took)
			cap.push_back(tx_bit_i);
		took <= tx_valid_i && tx_ready_o;
		tx_ready_o <= slow ? !tx_ready_o : 1'b1;
	end
	task automatic send(input logic [7:0] b [$]);
		@(posedge clk_i) rx_sof_o <= 1'b1;
		@(posedge clk_i) rx_sof_o <= 1'b0;
		foreach (b[i]) for (int k = 0; k < 8; k++) begin
			rx_bit_o <= b[i][k];
			rx_valid_o <= 1'b1;
			@(posedge clk_i);
		end
		rx_valid_o <= 1'b0;
		rx_bit_o <= !rx_bit_o;
		rx_eof_o <= 1'b1;
		@(posedge clk_i) rx_eof_o <= 1'b0;
	endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the mac frame fcs unit
`timescale 1ns/1ps
module testbench;
	import mff_pkg::*;
	logic         clk_i = 0, rstn_i = 0, tx_start_i = 0;
	mff_bus_req_t bus_i = '0;
	logic [6:0]   tx_len_i = '0;
	logic [7:0]   rdata_o, ack_seq_o, seen;
	logic [4:0]   hdr_len_o;
	logic         irq_o, tx_ready_i, tx_bit_o, tx_valid_o, tx_busy_o, ack_req_o, sec_hdr_o;
	logic         rx_bit_i, rx_valid_i, rx_sof_i, rx_eof_i;
	int           num_errors = 0, n_compared = 0, acks = 0;
	always #2 clk_i = !clk_i;
	mff_fcs_unit uut (.clk_i, .rstn_i, .bus_i, .rdata_o, .irq_o, .tx_start_i, .tx_len_i,
		.tx_ready_i, .tx_bit_o, .tx_valid_o, .tx_busy_o, .rx_bit_i, .rx_valid_i, .rx_sof_i,
		.rx_eof_i, .ack_req_o, .ack_seq_o, .sec_hdr_o, .hdr_len_o);
	mff_radio_model m (.clk_i, .tx_bit_i(tx_bit_o), .tx_valid_i(tx_valid_o),
		.tx_ready_o(tx_ready_i), .rx_bit_o(rx_bit_i), .rx_valid_o(rx_valid_i),
		.rx_sof_o(rx_sof_i), .rx_eof_o(rx_eof_i));
	always @(posedge clk_i) if (ack_req_o === 1'b1) begin
		seen <= ack_seq_o;
		acks <= acks + 1;
	end
	task chk(input logic [39:0] g, input logic [39:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task xfer(input logic [5:0] a, input logic [7:0] d, input logic w);
		bus_i <= '{a, d, w, !w};
		@(posedge clk_i) bus_i <= '0;
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		xfer(a, d, 1'b1);
		@(posedge clk_i);
	endtask
	task rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] msk = 8'hFF);
		xfer(a, 8'h00, 1'b0);
		#1 chk(rdata_o & msk, e);
		@(posedge clk_i);
	endtask
	function automatic logic [15:0] fcs(input logic [7:0] q [$]);
		logic [15:0] c;
		logic        fb;
		c = 16'h0000;
		foreach (q[i]) for (int k = 0; k < 8; k++) begin
			fb = q[i][k] ^ c[15];
			c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
		end
		return {<<{c}};
	endfunction
	task rxf(input logic [7:0] q [$], input logic bad);
		logic [15:0] f;
		f = fcs(q) ^ {15'h0000, bad};
		q.push_back(f[7:0]);
		q.push_back(f[15:8]);
		m.send(q);
		repeat (4) @(posedge clk_i);
	endtask
	task run_tx(input logic [39:0] ld, input logic [39:0] ex);
		logic [39:0] got;
		int          k;
		for (int i = 0; i < 5; i++) wr(6'h20 + 6'(i), ld[8*i+:8]);
		m.cap.delete();
		tx_len_i <= 7'h05;
		tx_start_i <= 1'b1;
		@(posedge clk_i) tx_start_i <= 1'b0;
		@(posedge clk_i);
		k = 0;
		while (tx_busy_o !== 1'b0 && k < 2000) begin
			@(posedge clk_i);
			k++;
		end
		chk(tx_busy_o, 1'b0);
		repeat (3) @(posedge clk_i);
		got = '0;
		foreach (m.cap[j]) if (j < 40) got[j] = m.cap[j];
		chk(40'(m.cap.size()), 40'd40);
		chk(got, ex);
	endtask
	task t_reset;
		rd(ADDR_CTRL_ONE, 8'h22);
		rd(ADDR_PHY_STATUS, 8'h00);
		rd(6'h10, 8'h00);
		wr(ADDR_SEQ, 8'hFF);
		rd(ADDR_SEQ, 8'h00);
		chk(irq_o, 1'b0);
	endtask
	task t_tx;
		tx_len_i <= 7'h02;
		tx_start_i <= 1'b1;
		@(posedge clk_i) tx_start_i <= 1'b0;
		@(posedge clk_i);
		chk(tx_busy_o, 1'b0);
		m.slow = 1'b1;
		run_tx(40'h0000_6A_00_02, 40'h79_E4_6A_00_02);
		wr(ADDR_CTRL_ONE, 8'h02);
		m.slow = 1'b0;
		run_tx(40'h22_11_6A_00_02, 40'h22_11_6A_00_02);
		wr(ADDR_CTRL_ONE, 8'h22);
	endtask
	task t_rx;
		for (int i = 0; i < 4; i++) begin
			rxf('{i[1] ? 8'h0A : 8'h02, i[0] ? 8'h10 : 8'h00, 8'h10 + 8'(i)}, 1'b0);
			rd(ADDR_CLASS, 8'(i));
			chk(sec_hdr_o, i[1]);
			rd(ADDR_SEQ, 8'h10 + 8'(i));
			rd(ADDR_PHY_STATUS, 8'h80);
		end
		rxf('{8'h02, 8'h00, 8'h6A}, 1'b1);
		rd(ADDR_PHY_STATUS, 8'h00);
		repeat (20) @(posedge clk_i);
		rd(ADDR_PHY_STATUS, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h03, 8'h03);
		rxf('{8'h41, 8'h88, 8'h33, 8'hCD, 8'hAB, 8'h01, 8'h00, 8'h02, 8'h00}, 1'b0);
		chk(hdr_len_o, 5'd9);
		rxf('{8'h01, 8'h88, 8'h34, 8'hCD, 8'hAB, 8'h01, 8'h00, 8'hCD, 8'hAB, 8'h02, 8'h00}, 1'b0);
		chk(hdr_len_o, 5'd11);
		rxf('{8'h01, 8'h80, 8'h35, 8'hCD, 8'hAB, 8'h02, 8'h00}, 1'b0);
		chk(hdr_len_o, 5'd7);
	endtask
	task t_aack;
		wr(ADDR_CFG, 8'h01);
		wr(ADDR_IRQ_STATUS, 8'hFF);
		rxf('{8'h21, 8'h00, 8'h5C}, 1'b1);
		rd(ADDR_IRQ_STATUS, 8'h00, 8'h01);
		rd(ADDR_PHY_STATUS, 8'h80);
		rxf('{8'h21, 8'h00, 8'h5C}, 1'b0);
		rd(ADDR_IRQ_STATUS, 8'h04, 8'h05);
		chk(acks, 0);
		wr(ADDR_CFG, 8'h03);
		rxf('{8'h21, 8'h00, 8'h5D}, 1'b0);
		chk(acks, 1);
		chk(seen, 8'h5D);
		rd(ADDR_IRQ_STATUS, 8'h01, 8'h01);
		rxf('{8'h21, 8'h20, 8'h5E}, 1'b0);
		chk(acks, 1);
		wr(ADDR_CFG, 8'h07);
		rxf('{8'h21, 8'h20, 8'h5F}, 1'b0);
		chk(acks, 2);
		chk(seen, 8'h5F);
		wr(ADDR_CFG, 8'h00);
	endtask
	task t_irq;
		wr(ADDR_IRQ_STATUS, 8'hFF);
		rd(ADDR_IRQ_STATUS, 8'h00);
		rxf('{8'h02, 8'h00, 8'h6A}, 1'b0);
		chk(irq_o, 1'b0);
		wr(ADDR_IRQ_MASK, 8'h01);
		chk(irq_o, 1'b1);
		wr(ADDR_IRQ_STATUS, 8'h01);
		chk(irq_o, 1'b0);
	endtask
	task results;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		t_reset;
		t_tx;
		t_rx;
		t_aack;
		t_irq;
		results;
	end
	initial begin
		#200000;
		num_errors++;
		results;
	end
endmodule
